/* File: verilog/mcs_misc_regs.v */
// misc control/status register bank with apb slave and interrupt
//
// Operation
// (RL1) read-only revision byte, main and sub nibble
// (RL2) lockout bit guards registers, resets to one
// (RL3) lockout engages on resume when enabled
// (RL4) pend bit zero alters shared-bit writes; here pend at one holds back the remote-wake memory update instead
// (RL5) firmware sets pend before shared writes
// (RL6) seven-bit read/write scratch field
// (RL7) notepad top bit enables resume interrupt
// (RL8) remote-wake memory reads zero without feature
// (RL9) remote wake sets memory, global clears
// (RL10) init zero until clocks run, sw-proof
// (RL11) suspended flag set until clocks restart
// (RL12) package bit captured after hardware reset
// (RL13) feature enable bit, read/write
// (RL14) board-feature enable bit, read/write
// (RL15) pull-up enable drives supply or floats
// (RL16) reserved bits read zero, ignore writes
//
// Chosen here: register access over APB.
`include "mcs_regs.vh"
`default_nettype none

module mcs_misc_regs (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // device events
  input wire sw_reset,
  input wire suspend_enter,
  input wire resume_global,
  input wire usb_reset,
  input wire remote_wake_input_n,
  input wire clk_restart,
  input wire package_strap,
  // control outputs to the rest of the device
  output reg feature_enable,
  output reg board_feature_enable,
  output reg lockout_enable,
  output reg shared_pend,
  output reg lock_state_bit,
  // pull-up supply pin
  output reg pullup_supply_out,
  output reg pullup_supply_oe_n,
  // interrupt
  output reg irq
);

  // internal state
  reg [7:0] note_reg; // scratch field plus resume enable
  reg feature_enable_reg; // later-revision features
  reg board_feature_enable_reg; // board-affecting features
  reg loe_reg; // lockout enable
  reg pull_reg; // pull-up enable
  reg lock_reg; // one means lock_state_bit
  reg pend_reg; // shared write qualifier
  reg rwm_reg; // remote-wake memory
  reg rwm_hold_reg; // deferred remote-wake value
  reg rwm_defer_reg; // a deferred update is waiting
  reg init_reg; // device initialised
  reg susp_reg; // suspended flag
  reg pkg_reg; // captured package variant
  reg pkg_done_reg; // strap capture finished
  reg wake_seen_reg; // first wake of this suspend taken
  reg [2:0] istat_reg; // sticky interrupt status
  reg [2:0] imask_reg; // interrupt mask

  // bus decode
  wire setup_ph; // first cycle of a transfer
  wire access_ok; // completing cycle of a transfer
  wire wr_en; // write takes effect this edge
  wire hit; // address maps to a register
  wire wr_open; // writes allowed by the lockout
  reg [7:0] rd_data; // read mux result

  // wake handling
  wire remote_req; // remote wake request while suspended
  wire global_req; // global resume or usb reset
  wire wake_evt; // first wake of a suspend
  wire rwm_new; // value the memory bit takes on wake
  wire resume_done; // clocks restart after suspend
  wire lock_engage; // lockout fires this edge
  wire [2:0] ievt; // interrupt events this cycle
  wire [2:0] iclr; // write-one-to-clear strobes
  wire [2:0] igate; // resume bit gated by its enable
  wire [7:0] mcs_rd; // assembled misc register

  // the decode is taken in the setup cycle and the answer is registered
  // there, so every transfer finishes in its first access cycle, no waits
  assign setup_ph = psel & ~penable;
  // pready stands only in the first access cycle, so this is one edge
  assign access_ok = psel & penable & pready;
  // an error cycle never writes, whatever the address
  assign wr_en = access_ok & pwrite & ~pslverr;

  // while locked only the lock register and the interrupt status clears take writes
  assign wr_open = lock_reg; // RL2

  // address map check
  assign hit = (paddr == `MCS_ADDR_REV) |
               (paddr == `MCS_ADDR_LOCK) |
               (paddr == `MCS_ADDR_PEND) |
               (paddr == `MCS_ADDR_NOTE) |
               (paddr == `MCS_ADDR_MCS) |
               (paddr == `MCS_ADDR_ISTAT) |
               (paddr == `MCS_ADDR_IMASK);

  // the remote pin is active low and only counts while suspended
  assign remote_req = susp_reg & ~remote_wake_input_n;
  assign global_req = resume_global | usb_reset;
  // the pin is a level with no enable of its own; a request still held
  // after the clocks restart is ignored until the next suspend

  // only the first wake of each suspend updates the memory bit
  assign wake_evt = susp_reg & ~wake_seen_reg & (remote_req | global_req);

  // global wins when both arrive together
  assign rwm_new = remote_req & ~global_req; // RL9

  // resume sequence ends when clocks come back while suspended
  assign resume_done = susp_reg & clk_restart;

  // lockout engages at every resume when enabled
  assign lock_engage = resume_done & loe_reg; // RL3

  // interrupt events
  assign ievt[`MCS_IRQ_RESUME] = wake_evt;
  assign ievt[`MCS_IRQ_SUSPEND] = suspend_enter & ~susp_reg;
  assign ievt[`MCS_IRQ_LOCK] = lock_engage;

  // write-one-to-clear strobes
  assign iclr = (wr_en && paddr == `MCS_ADDR_ISTAT) ? pwdata[2:0] : 3'h0;

  // resume needs its own enable as well as the mask
  assign igate = {2'b11, note_reg[`MCS_BIT_WIE]}; // RL7

  // misc register as software sees it
  assign mcs_rd[`MCS_BIT_RWM] = rwm_reg & feature_enable_reg; // RL8
  assign mcs_rd[`MCS_BIT_INIT] = init_reg;
  assign mcs_rd[`MCS_BIT_SUSP] = susp_reg;
  assign mcs_rd[`MCS_BIT_PKG] = pkg_reg;
  assign mcs_rd[`MCS_BIT_FEATURE_ENABLE] = feature_enable_reg;
  assign mcs_rd[`MCS_BIT_BOARD_FEATURE_ENABLE] = board_feature_enable_reg;
  assign mcs_rd[`MCS_BIT_LOE] = loe_reg;
  assign mcs_rd[`MCS_BIT_PULL] = pull_reg;

  // read mux, unused upper bits read zero
  always @* begin
    rd_data = 8'h00;
    case (paddr)
      `MCS_ADDR_REV: begin
        rd_data = `MCS_REV_VALUE; // RL1
      end
      `MCS_ADDR_LOCK: begin
        rd_data = {7'h00, lock_reg}; // RL16
      end
      `MCS_ADDR_PEND: begin
        rd_data = {7'h00, pend_reg}; // RL16
      end
      `MCS_ADDR_NOTE: begin
        rd_data = note_reg; // RL6
      end
      `MCS_ADDR_MCS: begin
        rd_data = mcs_rd;
      end
      `MCS_ADDR_ISTAT: begin
        rd_data = {5'h00, istat_reg};
      end
      `MCS_ADDR_IMASK: begin
        rd_data = {5'h00, imask_reg};
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  // apb answer: registered, pready high in the first access cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pready <= 1'b1;
      prdata <= {24'h000000, (hit & ~pwrite) ? rd_data : 8'h00};
      pslverr <= ~hit;
    end else begin
      // drop ready and error once the transfer completes; prdata keeps its value
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // lock register: firmware writes, hardware locks on resume
  // the lock write is not gated by the lock itself, otherwise firmware
  // could never reopen the bank after a resume
  always @(posedge clk) begin
    if (!rst_n) begin
      lock_reg <= `MCS_RST_LOCK; // RL2
    end else if (lock_engage) begin
      // hardware lock wins over a write in the same cycle
      lock_reg <= 1'b0; // RL3
    end else if (wr_en && paddr == `MCS_ADDR_LOCK) begin
      lock_reg <= pwdata[0]; // RL16
    end
  end

  // pend register, reset also by software reset
  always @(posedge clk) begin
    if (!rst_n || sw_reset) begin
      pend_reg <= `MCS_RST_PEND; // RL4
    end else if (wr_en && wr_open && paddr == `MCS_ADDR_PEND) begin
      pend_reg <= pwdata[0]; // RL16
    end
  end

  // notepad: scratch bits and resume interrupt enable
  always @(posedge clk) begin
    if (!rst_n) begin
      note_reg <= `MCS_RST_NOTE;
    end else if (wr_en && wr_open && paddr == `MCS_ADDR_NOTE) begin
      // scratch survives a software reset so state can be restored
      note_reg <= pwdata[7:0]; // RL6
    end
  end

  // writable control bits of the misc register
  // software reset returns the features to earlier-revision behaviour
  always @(posedge clk) begin
    if (!rst_n || sw_reset) begin
      {feature_enable_reg, board_feature_enable_reg, loe_reg, pull_reg} <= `MCS_RST_MCS_CTRL;
    end else if (wr_en && wr_open && paddr == `MCS_ADDR_MCS) begin
      feature_enable_reg <= pwdata[`MCS_BIT_FEATURE_ENABLE]; // RL13
      board_feature_enable_reg <= pwdata[`MCS_BIT_BOARD_FEATURE_ENABLE]; // RL14
      // firmware must settle this before suspending
      loe_reg <= pwdata[`MCS_BIT_LOE]; // RL3
      pull_reg <= pwdata[`MCS_BIT_PULL]; // RL15
    end
  end

  // remote-wake memory; while pend is set the update is held back
  // so firmware writing shared bits never races the hardware
  // a second wake in one suspend is ignored: the first-wake marker holds
  // it off until the resume sequence completes
  always @(posedge clk) begin
    if (!rst_n) begin
      rwm_reg <= 1'b0;
      rwm_hold_reg <= 1'b0;
      rwm_defer_reg <= 1'b0;
    end else if (wake_evt && pend_reg) begin
      rwm_hold_reg <= rwm_new; // RL4
      rwm_defer_reg <= 1'b1;
    end else if (wake_evt) begin
      rwm_reg <= rwm_new; // RL9
      rwm_defer_reg <= 1'b0;
    end else if (rwm_defer_reg && !pend_reg) begin
      // pend released: apply the held value
      rwm_reg <= rwm_hold_reg; // RL4
      rwm_defer_reg <= 1'b0;
    end
  end

  // suspended flag and first-wake marker
  always @(posedge clk) begin
    if (!rst_n) begin
      susp_reg <= 1'b0;
      wake_seen_reg <= 1'b0;
    end else if (resume_done) begin
      susp_reg <= 1'b0; // RL11
      wake_seen_reg <= 1'b0;
    end else if (suspend_enter) begin
      susp_reg <= 1'b1; // RL11
    end else if (wake_evt) begin
      wake_seen_reg <= 1'b1;
    end
  end

  // initialised flag: only hardware reset clears it
  // a software reset leaves it set, so firmware can tell a soft restart
  // from a power-up
  always @(posedge clk) begin
    if (!rst_n) begin
      init_reg <= 1'b0; // RL10
    end else if (clk_restart) begin
      init_reg <= 1'b1; // RL10
    end
  end

  // package strap caught once, in the first cycle after reset release
  // the strap must be settled when reset is released; later changes are
  // ignored until the next hardware reset
  always @(posedge clk) begin
    if (!rst_n) begin
      pkg_reg <= 1'b0;
      pkg_done_reg <= 1'b0;
    end else if (!pkg_done_reg) begin
      pkg_reg <= package_strap; // RL12
      pkg_done_reg <= 1'b1;
    end
  end

  // sticky interrupt status, set wins over a clear
  always @(posedge clk) begin
    if (!rst_n) begin
      istat_reg <= `MCS_RST_IRQ;
    end else begin
      // an event in the cycle of its clear leaves the bit set, so firmware
      // never loses an event that lands while it acknowledges the last one
      istat_reg <= (istat_reg & ~iclr) | ievt;
    end
  end

  // interrupt mask
  always @(posedge clk) begin
    if (!rst_n) begin
      imask_reg <= `MCS_RST_IRQ;
    end else if (wr_en && wr_open && paddr == `MCS_ADDR_IMASK) begin
      imask_reg <= pwdata[2:0];
    end
  end

  // level interrupt, one cycle behind the status bits
  // the resume bit needs its notepad enable as well as its mask bit;
  // the other two sources are gated by the mask alone
  // registering the output keeps glitches off the pin at the cost of a cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_reg & imask_reg & igate); // RL7
    end
  end

  // registered copies of control state for the rest of the device
  always @(posedge clk) begin
    if (!rst_n) begin
      feature_enable <= 1'b0;
      board_feature_enable <= 1'b0;
      lockout_enable <= 1'b0;
      shared_pend <= 1'b0;
      lock_state_bit <= `MCS_RST_LOCK;
    end else begin
      feature_enable <= feature_enable_reg; // RL13
      board_feature_enable <= board_feature_enable_reg; // RL14
      lockout_enable <= loe_reg;
      shared_pend <= pend_reg; // RL4
      lock_state_bit <= lock_reg;
    end
  end

  // pull-up pin: drive high or float; enable is active low
  // floating the pin looks like a disconnect to the host; the driven
  // level is always high, so the data output only mirrors the enable
  always @(posedge clk) begin
    if (!rst_n) begin
      pullup_supply_out <= 1'b0;
      pullup_supply_oe_n <= 1'b1;
    end else begin
      pullup_supply_out <= pull_reg; // RL15
      pullup_supply_oe_n <= ~pull_reg; // RL15
    end
  end

endmodule

`default_nettype wire

/* File: verilog/mcs_regs.vh */
// register indices, addresses, field positions and reset values of the bank
`ifndef MCS_REGS_VH
`define MCS_REGS_VH

// register indices; the byte address is four times the index
`define MCS_IDX_REV 8'h18
`define MCS_IDX_LOCK 8'h19
`define MCS_IDX_PEND 8'h1A
`define MCS_IDX_NOTE 8'h1B
`define MCS_IDX_MCS 8'h1C
`define MCS_IDX_ISTAT 8'h20
`define MCS_IDX_IMASK 8'h21

// byte addresses on the bus
`define MCS_ADDR_REV (`MCS_IDX_REV * 8'h04)
`define MCS_ADDR_LOCK (`MCS_IDX_LOCK * 8'h04)
`define MCS_ADDR_PEND (`MCS_IDX_PEND * 8'h04)
`define MCS_ADDR_NOTE (`MCS_IDX_NOTE * 8'h04)
`define MCS_ADDR_MCS (`MCS_IDX_MCS * 8'h04)
`define MCS_ADDR_ISTAT (`MCS_IDX_ISTAT * 8'h04)
`define MCS_ADDR_IMASK (`MCS_IDX_IMASK * 8'h04)

// revision value, arbitrary neutral value
`define MCS_REV_VALUE 8'h21

// reset values
`define MCS_RST_LOCK 1'b1
`define MCS_RST_PEND 1'b0
`define MCS_RST_NOTE 8'h00
`define MCS_RST_MCS_CTRL 4'h0
`define MCS_RST_IRQ 3'h0

// fields of the misc control/status register
`define MCS_BIT_RWM 7
`define MCS_BIT_INIT 6
`define MCS_BIT_SUSP 5
`define MCS_BIT_PKG 4
`define MCS_BIT_FEATURE_ENABLE 3
`define MCS_BIT_BOARD_FEATURE_ENABLE 2
`define MCS_BIT_LOE 1
`define MCS_BIT_PULL 0

// fields of the notepad register
`define MCS_BIT_WIE 7

// interrupt status and mask bits
`define MCS_IRQ_RESUME 0
`define MCS_IRQ_SUSPEND 1
`define MCS_IRQ_LOCK 2

`endif

/* File: testbench/mcs_misc_regs_asserts.sv */
// port checker for the misc register bank
`default_nettype none
module mcs_misc_regs_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events and control copies
  input wire logic sw_reset,
  input wire logic clk_restart,
  input wire logic lockout_enable,
  input wire logic lock_state_bit,
  input wire logic shared_pend,
  input wire logic feature_enable,
  input wire logic pullup_supply_out,
  input wire logic pullup_supply_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // the two phases of one transfer
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  AST_RDY_FIRST: assert property (s_setup ##1 s_access |-> pready)
    else $error("ready missing in first access cycle");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("ready stands too long");
  AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  AST_RD_HIGH: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_PULL: assert property (pullup_supply_oe_n == !pullup_supply_out)
    else $error("pull-up drive and enable disagree");
  AST_LOCK_RST: assert property (!$past(rst_n) |-> lock_state_bit && !shared_pend)
    else $error("lock or pend wrong after reset");
  // sw reset reaches the copies two edges later
  AST_SW_CLR: assert property (sw_reset |-> ##2 !(shared_pend || feature_enable))
    else $error("soft reset left control bits set");
  // the lock may only close on a restart with the enable set; a firmware write of zero also fails this check
  AST_LOCK_ENG: assert property ($fell(lock_state_bit)
    |-> $past(clk_restart, 2) && $past(lockout_enable, 2))
    else $error("lock closed without cause");
endmodule
bind mcs_misc_regs mcs_misc_regs_asserts u_chk (.clk, .rst_n, .psel, .penable, .prdata,
  .pready, .pslverr, .sw_reset, .clk_restart, .lockout_enable, .lock_state_bit,
  .shared_pend, .feature_enable, .pullup_supply_out, .pullup_supply_oe_n);
`default_nettype wire

/* File: testbench/mcs_misc_regs_tb_top.sv */
// self-checking bench of the misc register bank
`include "mcs_regs.vh"
`default_nettype none
module mcs_misc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // event masks for ev: remote, suspend, resume, usb reset, restart, sw
  localparam logic [5:0] rem = 6'h20, sus = 6'h10, glb = 6'h08;
  localparam logic [5:0] usb = 6'h04, rsr = 6'h02, swr = 6'h01;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic sw_reset, suspend_enter, resume_global, usb_reset, remote_wake_input_n;
  logic clk_restart, package_strap, feature_enable, board_feature_enable;
  logic lockout_enable, shared_pend, lock_state_bit, pullup_supply_out;
  logic pullup_supply_oe_n, irq, rerr;
  int fail_count, checks;
  mcs_misc_regs dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sw_reset, .suspend_enter, .resume_global, .usb_reset,
    .remote_wake_input_n, .clk_restart, .package_strap, .feature_enable,
    .board_feature_enable, .lockout_enable, .shared_pend, .lock_state_bit,
    .pullup_supply_out, .pullup_supply_oe_n, .irq);
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task report_and_stop;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one apb transfer; the answer is awaited, never assumed
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 10);
    if (n >= 10) begin
      fail_count++;
      report_and_stop();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, {24'h0, e});
  endtask
  // one-cycle event pulse, then let status and irq settle
  task ev(input logic [5:0] m);
    remote_wake_input_n <= !m[5];
    {suspend_enter, resume_global, usb_reset, clk_restart, sw_reset} <= m[4:0];
    @(posedge clk);
    remote_wake_input_n <= 1'b1;
    {suspend_enter, resume_global, usb_reset, clk_restart, sw_reset} <= 5'h00;
    repeat (3) @(posedge clk);
  endtask
  task t_regs;
    rd(`MCS_ADDR_REV, `MCS_REV_VALUE);
    wr(`MCS_ADDR_REV, 8'h00);
    rd(`MCS_ADDR_REV, `MCS_REV_VALUE);
    rd(`MCS_ADDR_LOCK, 8'h01);
    wr(`MCS_ADDR_LOCK, 8'hFF);
    rd(`MCS_ADDR_LOCK, 8'h01);
    rd(`MCS_ADDR_PEND, 8'h00);
    wr(`MCS_ADDR_PEND, 8'hFF);
    rd(`MCS_ADDR_PEND, 8'h01);
    chk({31'h0, shared_pend}, 32'h1);
    wr(`MCS_ADDR_PEND, 8'h00);
    rd(`MCS_ADDR_MCS, 8'h10);
    chk({31'h0, pullup_supply_oe_n}, 32'h1);
    wr(`MCS_ADDR_NOTE, 8'hFF);
    rd(`MCS_ADDR_NOTE, 8'hFF);
    wr(`MCS_ADDR_NOTE, 8'h2A);
    rd(`MCS_ADDR_NOTE, 8'h2A);
    wr(`MCS_ADDR_MCS, 8'hFF);
    rd(`MCS_ADDR_MCS, 8'h1F);
    chk({29'h0, feature_enable, board_feature_enable, lockout_enable}, 32'h7);
    chk({30'h0, pullup_supply_out, pullup_supply_oe_n}, 32'h2);
    apb(1'b0, 8'h7C, 32'h0);
    chk({rerr, rdat[30:0]}, 32'h80000000);
  endtask
  task t_init;
    ev(rsr);
    rd(`MCS_ADDR_MCS, 8'h5F);
    ev(swr);
    rd(`MCS_ADDR_MCS, 8'h50);
    rd(`MCS_ADDR_NOTE, 8'h2A);
    chk({31'h0, pullup_supply_out}, 32'h0);
  endtask
  task t_wake;
    wr(`MCS_ADDR_IMASK, 8'h07);
    wr(`MCS_ADDR_NOTE, 8'h80);
    wr(`MCS_ADDR_MCS, 8'h08);
    ev(sus);
    rd(`MCS_ADDR_MCS, 8'h78);
    wr(`MCS_ADDR_ISTAT, 8'h02);
    ev(6'h00);
    chk({31'h0, irq}, 32'h0);
    ev(rem);
    rd(`MCS_ADDR_MCS, 8'hF8);
    chk({31'h0, irq}, 32'h1);
    ev(rsr);
    rd(`MCS_ADDR_MCS, 8'hD8);
    wr(`MCS_ADDR_ISTAT, 8'h07);
    ev(6'h00);
    chk({31'h0, irq}, 32'h0);
    wr(`MCS_ADDR_MCS, 8'h00);
    rd(`MCS_ADDR_MCS, 8'h50);
    wr(`MCS_ADDR_MCS, 8'h08);
    ev(sus);
    ev(usb);
    ev(rsr);
    rd(`MCS_ADDR_MCS, 8'h58);
    ev(sus);
    ev(rem);
    ev(rsr);
    rd(`MCS_ADDR_MCS, 8'hD8);
  endtask
  task t_global;
    wr(`MCS_ADDR_IMASK, 8'h00);
    wr(`MCS_ADDR_MCS, 8'h0A);
    wr(`MCS_ADDR_ISTAT, 8'h07);
    ev(sus);
    ev(rem | glb);
    ev(rsr);
    rd(`MCS_ADDR_MCS, 8'h5A);
    chk({31'h0, irq}, 32'h0);
    rd(`MCS_ADDR_LOCK, 8'h00);
    chk({31'h0, lock_state_bit}, 32'h0);
    wr(`MCS_ADDR_NOTE, 8'h55);
    rd(`MCS_ADDR_NOTE, 8'h80);
    wr(`MCS_ADDR_LOCK, 8'h01);
    rd(`MCS_ADDR_LOCK, 8'h01);
    wr(`MCS_ADDR_IMASK, 8'h04);
    ev(6'h00);
    chk({31'h0, irq}, 32'h1);
    wr(`MCS_ADDR_ISTAT, 8'h07);
    ev(6'h00);
    chk({31'h0, irq}, 32'h0);
  endtask
  // pend held across a wake defers the memory update until it drops
  task t_pend;
    wr(`MCS_ADDR_MCS, 8'h08);
    wr(`MCS_ADDR_PEND, 8'h01);
    ev(sus);
    ev(rem);
    rd(`MCS_ADDR_MCS, 8'h78);
    wr(`MCS_ADDR_PEND, 8'h00);
    ev(rsr);
    rd(`MCS_ADDR_MCS, 8'hD8);
  endtask
  // main sequence: reset for six cycles, then the scenarios
  initial begin
    {rst_n, psel, penable, pwrite, sw_reset, suspend_enter} = 6'h00;
    {resume_global, usb_reset, clk_restart} = 3'h0;
    {remote_wake_input_n, package_strap} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_init();
    t_wake();
    t_global();
    t_pend();
    report_and_stop();
  end
endmodule
`default_nettype wire
